// ### include/rifsf_params.svh
// Constants for the receive FIFO formatter: codes, field positions, reset values
`ifndef RIFSF_PARAMS_SVH
`define RIFSF_PARAMS_SVH

// Acknowledge style status codes
`define RIFSF_ACK_COMPLETE     4'h1
`define RIFSF_ACK_BUSY_A       4'h5
`define RIFSF_ACK_DATA_ERROR   4'hd
`define RIFSF_ACK_CRC_ERROR    4'he

// Transaction code forced into every isochronous record header
`define RIFSF_TCODE_ISO_BLOCK  4'ha
`define RIFSF_HDR_TCODE_LSB    4

// Header bytes before payload in an isochronous packet
`define RIFSF_HDR_BYTES        3'h4

// Trailer field positions (status low nibble, observed ack, speed)
`define RIFSF_TRL_STAT_LSB     0
`define RIFSF_TRL_ACK_LSB      8
`define RIFSF_TRL_SPD_LSB      16

// End of cycle marker: only the cycle done bit is set
`define RIFSF_MARK_DONE_BIT    31

// Reset values
`define RIFSF_QUAD_RST         32'h0000_0000
`define RIFSF_LEN_RST          16'h0000
`define RIFSF_SPD_RST          2'h0
`define RIFSF_ACK_RST          4'h0

`endif

// ### include/rifsf_pkg.sv
// Types shared by the receive FIFO formatter modules
`default_nettype none

package rifsf_pkg;

  // Record sequencer states
  typedef enum logic [2:0] {
    RIFSF_IDLE,
    RIFSF_BODY,
    RIFSF_FLUSH,
    RIFSF_ACK,
    RIFSF_TRAIL
  } rifsf_state_type;

  // Bus speed code
  typedef logic [1:0] rifsf_speed_type;

  // Acknowledge style status nibble
  typedef logic [3:0] rifsf_code_type;

endpackage

`default_nettype wire

// ### hdl/rifsf_packer.sv
// Byte to quadlet packer with zero padding of a partial last quadlet
`default_nettype none
`include "rifsf_params.svh"

module rifsf_packer (
  input  wire logic        core_clk,    // Block clock
  input  wire logic        sys_rst,     // Synchronous reset, active high
  input  wire logic        in_valid,    // Byte offered
  input  wire logic [7:0]  in_byte,     // Byte value
  output logic             in_ready,    // Byte can be taken
  input  wire logic        flush,       // Emit held bytes as a padded quadlet
  output logic             quad_valid,  // Quadlet waiting
  output logic [31:0]      quad_data,   // Quadlet value
  input  wire logic        quad_take,   // Quadlet consumed
  output logic             busy         // Bytes or a quadlet still held
);
  import rifsf_pkg::*;

  logic [1:0]  cnt_q;    // Bytes held in the accumulator
  logic [31:0] acc_q;    // Partial quadlet, unused lanes zero
  logic        qv_q;     // Quadlet waiting
  logic [31:0] quad_q;   // Quadlet value

  // Place a byte in its lane; lane 0 is the top byte
  function automatic logic [31:0] lane_put(input logic [31:0] acc, input logic [1:0] lane,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = acc;
    case (lane)
      2'h0:    r[31:24] = b;
      2'h1:    r[23:16] = b;
      2'h2:    r[15:8]  = b;
      default: r[7:0]   = b;
    endcase
    return r;
  endfunction

  // New bytes wait while a finished quadlet is unread
  assign in_ready   = !qv_q;
  assign quad_valid = qv_q;
  assign quad_data  = quad_q;
  assign busy       = qv_q || (cnt_q != 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Accumulate, complete on the fourth byte, pad on flush
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q  <= 2'h0;
      acc_q  <= `RIFSF_QUAD_RST;
      qv_q   <= 1'b0;
      quad_q <= `RIFSF_QUAD_RST;
    end else begin
      if (quad_take) begin
        qv_q <= 1'b0;
      end
      if (in_valid && !qv_q) begin
        if (cnt_q == 2'h3) begin
          // Fourth byte closes the quadlet
          quad_q <= lane_put(acc_q, cnt_q, in_byte);
          qv_q   <= 1'b1;
          acc_q  <= `RIFSF_QUAD_RST;
        end else begin
          acc_q <= lane_put(acc_q, cnt_q, in_byte);
        end
        cnt_q <= cnt_q + 2'h1;
      end else if (flush && !qv_q && (cnt_q != 2'h0)) begin
        // Unused lanes are already zero
        quad_q <= acc_q;
        qv_q   <= 1'b1;
        acc_q  <= `RIFSF_QUAD_RST;
        cnt_q  <= 2'h0;
      end
    end
  end

endmodule

`default_nettype wire

// ### hdl/rifsf_formatter.sv
// Receive FIFO formatter: isochronous, snoop and end of cycle records
//
// What this block does
// - Header length decides payload bytes written
// - Two-bit tag field passed through unchanged
// - Header keeps the channel number
// - Isochronous header transaction code forced to A
// - First data byte lands in lane 0
// - Partial final payload quadlet is zero padded
// - Synchronization bits kept exactly as received
// - Isochronous trailer reports receive speed
// - Error status: complete, data or CRC error
// - Snoop mode accepts every packet on bus
// - Snoop captures are written to the FIFO
// - Snoop record holds whole or partial packet
// - Snoop trailer reports receive speed
// - Snoop status complete, else busy code
// - Snoop trailer holds the observed acknowledge
// - One marker quadlet per cycle end; cycle ends while a marker waits share it
// - Marker carries the cycle done flag
// - Speed code: 00, 01, 10; 11 unused
`default_nettype none
`include "rifsf_params.svh"

module rifsf_formatter (
  input  wire logic                      core_clk,      // Block clock, 40 MHz
  input  wire logic                      sys_rst,       // Synchronous reset, active high
  input  wire logic                      snoop_mode,    // Capture every bus packet
  input  wire logic                      rx_byte_valid, // Receiver offers a byte
  input  wire logic [7:0]                rx_byte,       // Received byte
  input  wire logic                      rx_first,      // Byte is first of a packet
  input  wire logic                      rx_last,       // Byte is last of a packet
  input  wire logic                      rx_iso,        // Packet is isochronous
  input  wire logic                      rx_cut,        // Packet ended early
  input  wire logic                      rx_crc_err,    // CRC check failed
  input  wire logic                      rx_data_err,   // Data length or content error
  input  wire rifsf_pkg::rifsf_speed_type rx_speed,     // Speed of the packet
  input  wire logic                      rx_ack_valid,  // Bus acknowledge seen
  input  wire rifsf_pkg::rifsf_code_type  rx_ack_code,  // Acknowledge value
  input  wire logic                      cycle_end,     // Isochronous cycle ended
  output logic                           rx_ready,      // Byte accepted this cycle
  output logic                           fifo_valid,    // Quadlet for the FIFO
  output logic [31:0]                    fifo_data,     // Quadlet value
  output logic                           fifo_last,     // Final quadlet of a record
  input  wire logic                      fifo_ready     // FIFO takes the quadlet
);
  import rifsf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  rifsf_state_type state_q;     // Record sequencer
  logic            snoop_q;     // Current record is a snoop capture
  logic            skip_q;      // Current packet is dropped
  logic [2:0]      hdr_cnt_q;   // Header bytes seen
  logic [15:0]     len_q;       // Length from the header
  logic [15:0]     remain_q;    // Payload bytes still to write
  logic            first_q;     // Next packed quadlet is the record header
  rifsf_speed_type spd_q;       // Speed of the current packet
  logic            crc_q;       // CRC failure seen
  logic            derr_q;      // Data error seen
  logic            cut_q;       // Packet was cut short
  rifsf_code_type  ack_q;       // Observed acknowledge
  logic            ack_got_q;   // Acknowledge captured
  logic            mark_pend_q; // Marker waiting for a record boundary
  logic            out_valid_q; // Output quadlet waiting
  logic [31:0]     out_data_q;  // Output quadlet
  logic            out_last_q;  // Output quadlet ends a record

  logic            take;        // Byte handshake completes
  logic            start;       // First byte of a packet taken in idle
  logic            accept_new;  // New packet is recorded
  logic            mode_snoop;  // Snoop handling for this byte
  logic            recording;   // Byte belongs to a recorded packet
  logic            pass;        // Byte goes to the packer
  logic            in_hdr;      // Byte is an isochronous header byte
  logic            can_load;    // Output stage can take a quadlet
  logic            pk_in_ready; // Packer can take a byte
  logic            pk_qvalid;   // Packer has a quadlet
  logic [31:0]     pk_qdata;    // Packer quadlet
  logic            pk_take;     // Packer quadlet moves to output
  logic            pk_busy;     // Packer still holds data
  logic            pk_flush;    // Pad and emit held bytes
  logic            trl_load;    // Trailer moves to output
  logic            mark_load;   // Marker moves to output

  ////////////////////////////////////////////////////////////////////////////
  // Status encoding helpers
  // Isochronous reception status
  function automatic rifsf_code_type iso_status(input logic crc, input logic derr,
                                                input logic cut);
    if (crc) begin
      return `RIFSF_ACK_CRC_ERROR;
    end else if (derr || cut) begin
      return `RIFSF_ACK_DATA_ERROR;
    end else begin
      return `RIFSF_ACK_COMPLETE;
    end
  endfunction

  // Trailer quadlet from speed, status and acknowledge
  function automatic logic [31:0] trailer(input rifsf_speed_type spd,
                                          input rifsf_code_type stat,
                                          input rifsf_code_type ack);
    logic [31:0] t;
    t = `RIFSF_QUAD_RST;
    t[`RIFSF_TRL_SPD_LSB +: 2]  = spd;
    t[`RIFSF_TRL_STAT_LSB +: 4] = stat;
    t[`RIFSF_TRL_ACK_LSB +: 4]  = ack;
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Byte routing
  // New bytes wait while a marker is due, so a marker never splits a record
  always_comb begin
    case (state_q)
      RIFSF_IDLE: rx_ready = pk_in_ready && !mark_pend_q;
      RIFSF_BODY: rx_ready = pk_in_ready;
      default:    rx_ready = 1'b0;
    endcase
  end

  assign take       = rx_byte_valid && rx_ready;
  assign start      = take && (state_q == RIFSF_IDLE) && rx_first;
  assign accept_new = snoop_mode || rx_iso;
  assign mode_snoop = (state_q == RIFSF_IDLE) ? snoop_mode : snoop_q;
  assign recording  = (start && accept_new) || ((state_q == RIFSF_BODY) && !skip_q);
  assign in_hdr     = hdr_cnt_q < `RIFSF_HDR_BYTES;
  // Snoop keeps every byte; isochronous keeps header plus length bytes
  assign pass       = take && recording && (mode_snoop || in_hdr || (remain_q != 16'h0));
  assign pk_flush   = (state_q == RIFSF_FLUSH);

  ////////////////////////////////////////////////////////////////////////////
  // Byte packer
  rifsf_packer u_packer (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .in_valid   (pass),
    .in_byte    (rx_byte),
    .in_ready   (pk_in_ready),
    .flush      (pk_flush),
    .quad_valid (pk_qvalid),
    .quad_data  (pk_qdata),
    .quad_take  (pk_take),
    .busy       (pk_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage arbitration
  assign can_load  = !out_valid_q || fifo_ready;
  assign pk_take   = pk_qvalid && can_load;
  assign trl_load  = (state_q == RIFSF_TRAIL) && can_load && !pk_busy;
  assign mark_load = (state_q == RIFSF_IDLE) && mark_pend_q && can_load;

  ////////////////////////////////////////////////////////////////////////////
  // Record sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= RIFSF_IDLE;
    end else begin
      case (state_q)
        RIFSF_IDLE: begin
          // First byte opens a record or a dropped packet
          if (start) begin
            if (rx_last) begin
              state_q <= accept_new ? RIFSF_FLUSH : RIFSF_IDLE;
            end else begin
              state_q <= RIFSF_BODY;
            end
          end
        end
        RIFSF_BODY: begin
          // Packet end, complete or cut short
          if (take && rx_last) begin
            state_q <= skip_q ? RIFSF_IDLE : RIFSF_FLUSH;
          end
        end
        RIFSF_FLUSH: begin
          // Wait until every payload quadlet has left the packer
          if (!pk_busy) begin
            state_q <= snoop_q ? RIFSF_ACK : RIFSF_TRAIL;
          end
        end
        RIFSF_ACK: begin
          // Snoop trailer needs the acknowledge that follows the packet
          if (ack_got_q) begin
            state_q <= RIFSF_TRAIL;
          end
        end
        RIFSF_TRAIL: begin
          if (trl_load) begin
            state_q <= RIFSF_IDLE;
          end
        end
        default: begin
          state_q <= RIFSF_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet attributes latched at the first byte
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      snoop_q <= 1'b0;
      skip_q  <= 1'b0;
      spd_q   <= `RIFSF_SPD_RST;
    end else if (start) begin
      snoop_q <= snoop_mode;
      skip_q  <= !accept_new;
      spd_q   <= rx_speed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Isochronous header parse and payload length count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hdr_cnt_q <= 3'h0;
      len_q     <= `RIFSF_LEN_RST;
      remain_q  <= `RIFSF_LEN_RST;
    end else if (state_q == RIFSF_TRAIL) begin
      hdr_cnt_q <= 3'h0;
      remain_q  <= `RIFSF_LEN_RST;
    end else if (pass && !mode_snoop) begin
      if (in_hdr) begin
        // Length sits in the first two header bytes, most significant first
        case (hdr_cnt_q)
          3'h0:    len_q[15:8] <= rx_byte;
          3'h1:    len_q[7:0]  <= rx_byte;
          3'h3:    remain_q    <= len_q;
          default: len_q       <= len_q;
        endcase
        hdr_cnt_q <= hdr_cnt_q + 3'h1;
      end else begin
        remain_q <= remain_q - 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reception status latched at the last byte
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      crc_q  <= 1'b0;
      derr_q <= 1'b0;
      cut_q  <= 1'b0;
    end else if (take && rx_last && recording) begin
      crc_q  <= rx_crc_err;
      derr_q <= rx_data_err;
      cut_q  <= rx_cut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Observed acknowledge capture after a snoop packet
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack_q     <= `RIFSF_ACK_RST;
      ack_got_q <= 1'b0;
    end else if (start) begin
      ack_got_q <= 1'b0;
    end else if (rx_ack_valid && !ack_got_q &&
                 ((state_q == RIFSF_FLUSH) || (state_q == RIFSF_ACK))) begin
      ack_q     <= rx_ack_code;
      ack_got_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // End of cycle marker request; a new cycle end beats the clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mark_pend_q <= 1'b0;
    end else if (cycle_end) begin
      mark_pend_q <= 1'b1;
    end else if (mark_load) begin
      mark_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Header quadlet tracking
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      first_q <= 1'b0;
    end else if (start) begin
      first_q <= 1'b1;
    end else if (pk_take) begin
      first_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output quadlet register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_valid_q <= 1'b0;
      out_data_q  <= `RIFSF_QUAD_RST;
      out_last_q  <= 1'b0;
    end else if (pk_take) begin
      // Length, tag, channel and sync pass as received; tcode is forced
      out_valid_q <= 1'b1;
      out_data_q  <= pk_qdata;
      out_last_q  <= 1'b0;
      if (first_q && !snoop_q) begin
        out_data_q[`RIFSF_HDR_TCODE_LSB +: 4] <= `RIFSF_TCODE_ISO_BLOCK;
      end
    end else if (trl_load) begin
      out_valid_q <= 1'b1;
      out_last_q  <= 1'b1;
      if (snoop_q) begin
        // Busy code marks a capture that was cut short
        out_data_q <= trailer(spd_q, cut_q ? `RIFSF_ACK_BUSY_A : `RIFSF_ACK_COMPLETE,
                              ack_q);
      end else begin
        out_data_q <= trailer(spd_q, iso_status(crc_q, derr_q, cut_q),
                              `RIFSF_ACK_RST);
      end
    end else if (mark_load) begin
      out_valid_q <= 1'b1;
      out_last_q  <= 1'b1;
      out_data_q  <= `RIFSF_QUAD_RST;
      out_data_q[`RIFSF_MARK_DONE_BIT] <= 1'b1;
    end else if (fifo_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  assign fifo_valid = out_valid_q;
  assign fifo_data  = out_data_q;
  assign fifo_last  = out_last_q;

endmodule

`default_nettype wire

// ### tb/rifsf_formatter_sva.sv
// Port checker for the receive FIFO formatter
`default_nettype none
module rifsf_formatter_sva (
  input wire logic        core_clk,      // Block clock
  input wire logic        sys_rst,       // Synchronous reset
  input wire logic        snoop_mode,    // Capture mode
  input wire logic        rx_byte_valid, // Byte offered
  input wire logic        rx_first,      // First byte
  input wire logic        rx_iso,        // Isochronous packet
  input wire logic        cycle_end,     // Cycle end pulse
  input wire logic        rx_ready,      // Byte taken
  input wire logic        fifo_valid,    // Quadlet offered
  input wire logic [31:0] fifo_data,     // Quadlet value
  input wire logic        fifo_last,     // Record end
  input wire logic        fifo_ready     // Quadlet taken
);
  timeunit 1ns;
  timeprecision 1ps;
  import rifsf_pkg::*;
  logic start_q; // Next quadlet opens a record
  logic iso_q;   // Latest packet forms an isochronous record
  ////////////////////////////////////////////////////////////////
  // Track record boundaries and record kind
  always_ff @(posedge core_clk) begin
    if (sys_rst) start_q <= 1'b1;
    else if (fifo_valid && fifo_ready) start_q <= fifo_last;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) iso_q <= 1'b0;
    else if (rx_byte_valid && rx_ready && rx_first) iso_q <= rx_iso && !snoop_mode;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  chk_out_held: assert property (fifo_valid && !fifo_ready |=>
    fifo_valid && $stable(fifo_data) && $stable(fifo_last)) else $error("quadlet dropped");
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
    !fifo_valid && !fifo_last && fifo_data == 32'h0) else $error("reset not clear");
  chk_marker_only: assert property (fifo_valid && fifo_last && fifo_data[31] |->
    fifo_data[30:0] == 31'h0) else $error("marker has other bits");
  chk_speed_code: assert property (fifo_valid && fifo_last && !fifo_data[31] |->
    fifo_data[17:16] != 2'b11) else $error("unused speed code");
  chk_status_code: assert property (fifo_valid && fifo_last && !fifo_data[31] |->
    fifo_data[3:0] inside {4'h1, 4'h5, 4'hd, 4'he}) else $error("bad status");
  chk_iso_tcode: assert property (fifo_valid && start_q && !fifo_last && iso_q |->
    fifo_data[7:4] == 4'ha) else $error("iso tcode wrong");
  chk_iso_noack: assert property (fifo_valid && fifo_last && !fifo_data[31] && iso_q |->
    fifo_data[11:8] == 4'h0) else $error("iso trailer ack");
  chk_marker_due: assert property (cycle_end |-> ##[1:600]
    (fifo_valid && fifo_last && fifo_data == 32'h8000_0000)) else $error("no marker");
  chk_snoop_out: assert property (rx_byte_valid && rx_ready && rx_first && snoop_mode
    |-> ##[1:60] fifo_valid) else $error("snoop not written");
  cov_stall: cover property (fifo_valid && !fifo_ready);
  cov_marker: cover property (fifo_valid && fifo_data == 32'h8000_0000);
  cov_iso: cover property (fifo_valid && start_q && iso_q);
endmodule
bind rifsf_formatter rifsf_formatter_sva u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
  .snoop_mode(snoop_mode), .rx_byte_valid(rx_byte_valid), .rx_first(rx_first),
  .rx_iso(rx_iso), .cycle_end(cycle_end), .rx_ready(rx_ready), .fifo_valid(fifo_valid),
  .fifo_data(fifo_data), .fifo_last(fifo_last), .fifo_ready(fifo_ready));
`default_nettype wire

// ### tb/rifsf_fifo_reader.sv
// Model of the host side reader of the receive FIFO
`default_nettype none
module rifsf_fifo_reader (
  input  wire logic        core_clk,   // Block clock
  input  wire logic        sys_rst,    // Synchronous reset
  input  wire logic        slow,       // Stall every other cycle
  input  wire logic        fifo_valid, // Quadlet offered
  input  wire logic [31:0] fifo_data,  // Quadlet value
  input  wire logic        fifo_last,  // Record end
  output logic             fifo_ready, // Reader takes quadlet
  output logic             taken,      // Quadlet taken at last edge
  output logic [32:0]      taken_data  // Last flag and quadlet taken
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // Ready pattern: steady or alternating
  always_ff @(posedge core_clk) begin
    if (sys_rst) fifo_ready <= 1'b0;
    else fifo_ready <= slow ? ~fifo_ready : 1'b1;
  end
  // Hand each whole quadlet to the bench
  always_ff @(posedge core_clk) begin
    taken <= !sys_rst && fifo_valid && fifo_ready;
    taken_data <= {fifo_last, fifo_data};
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the receive FIFO formatter
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rifsf_pkg::*;
  logic core_clk, sys_rst, snoop_mode, rx_byte_valid, rx_first, rx_last, rx_iso;
  logic rx_cut, rx_crc_err, rx_data_err, rx_ack_valid, cycle_end, rx_ready;
  logic fifo_valid, fifo_last, fifo_ready, slow, taken;
  logic [7:0] rx_byte;
  logic [31:0] fifo_data;
  logic [32:0] taken_data;
  rifsf_speed_type rx_speed;
  rifsf_code_type rx_ack_code;
  logic [32:0] got[$];
  logic [32:0] exp[$];
  int checks = 0;
  int failures = 0;
  rifsf_formatter dut (.core_clk(core_clk), .sys_rst(sys_rst), .snoop_mode(snoop_mode),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_first(rx_first),
    .rx_last(rx_last), .rx_iso(rx_iso), .rx_cut(rx_cut), .rx_crc_err(rx_crc_err),
    .rx_data_err(rx_data_err), .rx_speed(rx_speed), .rx_ack_valid(rx_ack_valid),
    .rx_ack_code(rx_ack_code), .cycle_end(cycle_end), .rx_ready(rx_ready),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_last(fifo_last),
    .fifo_ready(fifo_ready));
  rifsf_fifo_reader reader (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_last(fifo_last),
    .fifo_ready(fifo_ready), .taken(taken), .taken_data(taken_data));
  ////////////////////////////////////////////////////////////////
  // Clock and collection of taken quadlets
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (taken) got.push_back(taken_data);
  end
  ////////////////////////////////////////////////////////////////
  // Comparison, verdict and shared drivers
  task automatic check(input logic [32:0] seen, input logic [32:0] want, input string what);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Offer bytes one by one, each held until the block takes it
  task automatic send_pkt(input logic [7:0] b[$], input logic iso, input logic [2:0] flg,
                          input rifsf_speed_type spd);
    logic ok;
    for (int k = 0; k < b.size(); k++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= b[k];
      rx_first <= (k == 0);
      rx_last <= (k == b.size() - 1);
      {rx_iso, rx_speed, rx_cut, rx_crc_err, rx_data_err} <= {iso, spd, flg};
      do begin
        @(negedge core_clk);
        ok = rx_ready;
        @(posedge core_clk);
      end while (!ok);
    end
    rx_byte_valid <= 1'b0;
  endtask
  // Expected payload quadlets, first byte in lane 0, zero padded
  task automatic add_body(input logic [7:0] b[$], input int start, input int n);
    logic [31:0] w;
    for (int k = 0; k < n; k += 4) begin
      w = 32'h0;
      for (int j = 0; j < 4; j++) if (k + j < n) w[31 - 8 * j -: 8] = b[start + k + j];
      exp.push_back({1'b0, w});
    end
  endtask
  task automatic expect_all(input string what);
    int n = 0;
    while (got.size() < exp.size() && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    repeat (8) @(posedge core_clk);
    check(33'(got.size()), 33'(exp.size()), what);
    for (int k = 0; k < exp.size() && k < got.size(); k++) check(got[k], exp[k], what);
    got = {};
    exp = {};
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic iso_case(input logic [15:0] len, input rifsf_speed_type spd,
                          input logic [1:0] tag, input logic [1:0] err, input rifsf_code_type st);
    logic [7:0] b[$];
    logic [31:0] hdr;
    hdr = {len, tag, 6'h15, 4'h3, 4'h9};
    b = {hdr[31:24], hdr[23:16], hdr[15:8], hdr[7:0]};
    for (int k = 0; k < len + 4; k++) b.push_back(8'h40 + 8'(k));
    exp.push_back({1'b0, hdr[31:8], 4'ha, hdr[3:0]});
    add_body(b, 4, int'(len));
    exp.push_back({1'b1, 14'h0, spd, 12'h0, st});
    send_pkt(b, 1'b1, {1'b0, err}, spd);
    expect_all("iso record");
  endtask
  task automatic snoop_case(input int n, input logic cut, input rifsf_code_type ack,
                            input rifsf_code_type st, input rifsf_speed_type spd, input logic mark);
    logic [7:0] b[$];
    for (int k = 0; k < n; k++) b.push_back(8'h80 + 8'(k));
    snoop_mode <= 1'b1;
    add_body(b, 0, n);
    exp.push_back({1'b1, 14'h0, spd, 4'h0, ack, 4'h0, st});
    if (mark) exp.push_back({1'b1, 32'h8000_0000});
    fork
      send_pkt(b, 1'b0, {cut, 2'b00}, spd);
      if (mark) begin
        repeat (3) @(posedge core_clk);
        cycle_end <= 1'b1;
        @(posedge core_clk);
        cycle_end <= 1'b0;
      end
    join
    rx_ack_valid <= 1'b1;
    rx_ack_code <= ack;
    @(posedge core_clk);
    rx_ack_valid <= 1'b0;
    expect_all("snoop record");
  endtask
  task automatic idle_cases();
    logic [7:0] b[$];
    b = {8'h01, 8'h02, 8'h03, 8'h04};
    snoop_mode <= 1'b0;
    send_pkt(b, 1'b0, 3'b000, 2'b00);
    expect_all("non iso without snoop");
    exp.push_back({1'b1, 32'h8000_0000});
    cycle_end <= 1'b1;
    @(posedge core_clk);
    cycle_end <= 1'b0;
    expect_all("idle marker");
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    {sys_rst, snoop_mode, rx_byte_valid, rx_first, rx_last, rx_iso} = 6'b100000;
    {rx_cut, rx_crc_err, rx_data_err, rx_ack_valid, cycle_end, slow} = 6'b0;
    rx_byte = 8'h00;
    rx_speed = 2'b00;
    rx_ack_code = 4'h0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    iso_case(16'd5, 2'b01, 2'b00, 2'b00, 4'h1);
    iso_case(16'd4, 2'b10, 2'b01, 2'b10, 4'he);
    slow <= 1'b1;
    iso_case(16'd9, 2'b00, 2'b11, 2'b01, 4'hd);
    iso_case(16'd3, 2'b01, 2'b10, 2'b11, 4'he);
    snoop_case(6, 1'b0, 4'h2, 4'h1, 2'b10, 1'b1);
    slow <= 1'b0;
    snoop_case(7, 1'b1, 4'h4, 4'h5, 2'b01, 1'b0);
    idle_cases();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
